// ===== common/power_sequencer_defs.vh
// Purpose: constants for the power supply sequencer and monitor
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes:   definitions only
`ifndef POWER_SEQUENCER_DEFS_VH
`define POWER_SEQUENCER_DEFS_VH

// operating state codes
`define OP_STOPPED          2'h0
`define OP_STARTING         2'h1
`define OP_STARTED          2'h2
`define OP_STOPPING         2'h3

// per-channel threshold-relative state codes
`define CH_OFF              3'h0
`define CH_UNDER_TWO        3'h1
`define CH_UNDER_ONE        3'h2
`define CH_NOMINAL          3'h3
`define CH_OVER_ONE         3'h4
`define CH_OVER_TWO         3'h5

// nonvolatile store offsets
`define PROGRAM_OFFSET      32'h00000000
`define CONFIG_OFFSET       32'h0003f000

// timing
`define CLOCK_HZ            20000000
`define STEP_TIME_US        1000
`define STEP_CYCLES         ((`CLOCK_HZ / 1000000) * `STEP_TIME_US)
`define SETTLE_TIME_US      10000
`define SETTLE_CYCLES       ((`CLOCK_HZ / 1000000) * `SETTLE_TIME_US)

`endif

// ===== rtl/power_supply_sequencer_monitor.v
// Purpose: sequences regulator enables, classifies channels, drives flags
// Assumes: voltages and thresholds arrive already loaded from the
//          nonvolatile store; all inputs synchronous to clk
// Notes:   trimming converter and analog path are outside this block
`timescale 1ns/1ps
`include "power_sequencer_defs.vh"

module power_supply_sequencer_monitor #(
    parameter CHANNELS      = 22,
    parameter VW            = 16,
    parameter STEP_CYCLES   = `STEP_CYCLES,
    parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input  wire                   clk,
    input  wire                   reset,
    input  wire                   sequence_toggle_button,
    input  wire [CHANNELS*VW-1:0] channel_voltage,
    input  wire [VW-1:0]          off_level,
    input  wire [CHANNELS*VW-1:0] under_voltage_level_two,
    input  wire [CHANNELS*VW-1:0] under_voltage_level_one,
    input  wire [CHANNELS*VW-1:0] over_voltage_level_one,
    input  wire [CHANNELS*VW-1:0] over_voltage_level_two,
    input  wire [CHANNELS-1:0]    trim_allowed,
    input  wire [31:0]            flag_nominal_mask,
    input  wire [31:0]            flag_input_mask,
    input  wire [31:0]            general_inputs,
    output reg  [31:0]            regulator_enable,
    output reg  [31:0]            output_flags,
    output reg  [31:0]            input_status,
    output reg  [CHANNELS*VW-1:0] voltage_readback,
    output reg  [CHANNELS*3-1:0]  channel_state,
    output reg  [1:0]             op_state,
    output reg  [CHANNELS-1:0]    open_trim_enable,
    output reg  [CHANNELS-1:0]    closed_trim_enable,
    output reg  [31:0]            config_fetch_address,
    output reg  [31:0]            program_fetch_address
);

    // a 24-bit timer holds waits up to about 0.8 s at 20 MHz; widen CW for longer ones
    localparam CW = 24;
    // end points worked out at integer width, then cut to the register width on purpose
    localparam integer  LAST_CH_I    = CHANNELS - 1;
    localparam integer  STEP_END_I   = STEP_CYCLES - 1;
    localparam integer  SETTLE_END_I = SETTLE_CYCLES - 1;
    localparam [4:0]    LAST_CH      = LAST_CH_I[4:0];
    localparam [CW-1:0] STEP_END     = STEP_END_I[CW-1:0];
    localparam [CW-1:0] SETTLE_END   = SETTLE_END_I[CW-1:0];

    ////////////////////////////////////////////////////////////////////////
    // channel classification, combinational
    reg  [CHANNELS*3-1:0] next_class;
    reg  [VW-1:0]         v;
    reg  [CHANNELS-1:0]   nominal;
    integer               i;

    // ordered compare: off first, then under bands lowest first, then over bands highest first
    always @* begin
        next_class = {CHANNELS*3{1'b0}};
        nominal    = {CHANNELS{1'b0}};
        v          = {VW{1'b0}};
        for (i = 0; i < CHANNELS; i = i + 1) begin
            v = channel_voltage[i*VW +: VW];
            if (v <= off_level)
                next_class[i*3 +: 3] = `CH_OFF;
            else if (v < under_voltage_level_two[i*VW +: VW])
                next_class[i*3 +: 3] = `CH_UNDER_TWO;
            else if (v < under_voltage_level_one[i*VW +: VW])
                next_class[i*3 +: 3] = `CH_UNDER_ONE;
            else if (v > over_voltage_level_two[i*VW +: VW])
                next_class[i*3 +: 3] = `CH_OVER_TWO;
            else if (v > over_voltage_level_one[i*VW +: VW])
                next_class[i*3 +: 3] = `CH_OVER_ONE;
            else
                next_class[i*3 +: 3] = `CH_NOMINAL;
            nominal[i] = (next_class[i*3 +: 3] == `CH_NOMINAL);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer state
    reg              button_prev;
    reg              want_start;
    reg  [4:0]       step;
    reg  [CW-1:0]    timer;
    reg  [CHANNELS-1:0] enables;
    wire             press   = sequence_toggle_button & ~button_prev;
    wire             monitor = (op_state != `OP_STOPPED);
    wire [CHANNELS-1:0] all_ch = {CHANNELS{1'b1}};

    // one press toggles the direction requested; ignored in transit states
    always @(posedge clk) begin
        if (reset) begin
            button_prev <= 1'b0;
            op_state    <= `OP_STOPPED;
            step        <= 5'h00;
            timer       <= {CW{1'b0}};
            enables     <= {CHANNELS{1'b0}};
            want_start  <= 1'b1;
        end else begin
            button_prev <= sequence_toggle_button;
            case (op_state)
                `OP_STOPPED: begin
                    if (press && want_start) begin
                        op_state   <= `OP_STARTING;
                        want_start <= 1'b0;
                        step       <= 5'h00;
                        timer      <= {CW{1'b0}};
                        enables    <= {CHANNELS{1'b0}};
                    end else if (press) begin
                        // a press with the toggle pointing at stop only realigns it
                        want_start <= 1'b1;
                    end
                end
                `OP_STARTING: begin
                    // one enable per step, then wait for every channel to settle
                    if (enables != all_ch) begin
                        if (timer == STEP_END) begin
                            timer         <= {CW{1'b0}};
                            enables[step] <= 1'b1;
                            step          <= step + 5'h01;
                        end else begin
                            timer <= timer + {{CW-1{1'b0}}, 1'b1};
                        end
                    end else if (nominal == all_ch) begin
                        op_state <= `OP_STARTED;
                        timer    <= {CW{1'b0}};
                    end else if (timer == SETTLE_END) begin
                        // window counts from the last enable; too short a window retries forever
                        // a channel never made nominal: drop all and retry
                        enables <= {CHANNELS{1'b0}};
                        step    <= 5'h00;
                        timer   <= {CW{1'b0}};
                    end else begin
                        timer <= timer + {{CW-1{1'b0}}, 1'b1};
                    end
                end
                `OP_STARTED: begin
                    if (press && !want_start) begin
                        op_state   <= `OP_STOPPING;
                        want_start <= 1'b1;
                        step       <= LAST_CH;
                        timer      <= {CW{1'b0}};
                    end else if (press) begin
                        want_start <= 1'b0;
                    end
                end
                `OP_STOPPING: begin
                    // reverse order, last enabled switches off first
                    if (timer == STEP_END) begin
                        timer         <= {CW{1'b0}};
                        enables[step] <= 1'b0;
                        if (step == 5'h00)
                            op_state <= `OP_STOPPED;
                        else
                            step <= step - 5'h01;
                    end else begin
                        timer <= timer + {{CW-1{1'b0}}, 1'b1};
                    end
                end
                default: op_state <= `OP_STOPPED;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    reg [31:0] next_flags;

    // flags: nominal channels and inputs gated by masks
    always @* begin
        next_flags = 32'h00000000;
        next_flags[CHANNELS-1:0] = nominal & flag_nominal_mask[CHANNELS-1:0];
        next_flags = next_flags | (general_inputs & flag_input_mask);
    end

    // monitoring and flags are forced quiet while stopped
    always @(posedge clk) begin
        if (reset) begin
            regulator_enable      <= 32'h00000000;
            output_flags          <= 32'h00000000;
            input_status          <= 32'h00000000;
            voltage_readback      <= {CHANNELS*VW{1'b0}};
            channel_state         <= {CHANNELS*3{1'b0}};
            open_trim_enable      <= {CHANNELS{1'b0}};
            closed_trim_enable    <= {CHANNELS{1'b0}};
            config_fetch_address  <= `CONFIG_OFFSET;
            program_fetch_address <= `PROGRAM_OFFSET;
        end else begin
            regulator_enable <= {{32-CHANNELS{1'b0}}, enables};
            input_status     <= general_inputs;
            voltage_readback <= channel_voltage;
            channel_state    <= monitor ? next_class : {CHANNELS*3{1'b0}};
            output_flags     <= monitor ? next_flags : 32'h00000000;
            open_trim_enable <= (op_state == `OP_STARTING) ? trim_allowed
                                                            : {CHANNELS{1'b0}};
            closed_trim_enable <= (op_state == `OP_STARTED) ? trim_allowed
                                                             : {CHANNELS{1'b0}};
            // reloaded every cycle so an upset bit cannot linger
            config_fetch_address  <= `CONFIG_OFFSET;
            program_fetch_address <= `PROGRAM_OFFSET;
        end
    end

endmodule // power_supply_sequencer_monitor

// ===== testbench/power_supply_sequencer_monitor_tb.sv
// Purpose: self-checking bench for the power supply sequencer
// Assumes: step of 4 and settle of 16 cycles, regulator model alongside
// Notes:   state moves are matched against a queue of expected states
`timescale 1ns/1ps
module power_supply_sequencer_monitor_tb;
    logic         clk, reset, button;
    logic [15:0]  odd_level;
    logic [31:0]  gi, nmask, imask, regulator_enable, output_flags, input_status, cfg_a, prg_a;
    logic [21:0]  trim;
    logic [351:0] volts;
    logic [65:0]  channel_state;
    logic [1:0]   op_state, last_state;
    logic [1:0]   exp_q[$];
    logic [15:0]  lv[6] = '{16'h0040, 16'h0400, 16'h0a00, 16'h1000, 16'h1600, 16'h1c00};
    int           num_errors, n_tests, k;
    power_supply_sequencer_monitor #(.STEP_CYCLES(4), .SETTLE_CYCLES(16)) i_dut (
        .clk(clk), .reset(reset), .sequence_toggle_button(button), .channel_voltage(volts),
        .off_level(16'h0100), .under_voltage_level_two({22{16'h0800}}),
        .under_voltage_level_one({22{16'h0c00}}), .over_voltage_level_one({22{16'h1400}}),
        .over_voltage_level_two({22{16'h1800}}), .trim_allowed(trim), .flag_nominal_mask(nmask),
        .flag_input_mask(imask), .general_inputs(gi), .regulator_enable(regulator_enable),
        .output_flags(output_flags), .input_status(input_status), .voltage_readback(),
        .channel_state(channel_state), .op_state(op_state), .open_trim_enable(),
        .closed_trim_enable(), .config_fetch_address(cfg_a), .program_fetch_address(prg_a));
    regulator_bank i_regs (.clk(clk), .enable(regulator_enable), .odd_level(odd_level),
        .volts(volts));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // bounded wait on enables or state: until equal, or until no longer equal
    task automatic wait_for(input bit on_en, input logic [31:0] v, input bit differ);
        int n;
        for (n = 0; n < 3000 && ((on_en ? regulator_enable : op_state) === v) == differ; n++)
            @(negedge clk);
        if (n == 3000) begin
            check("wait bound", 32'h0, 32'h1);
            finish_test();
        end
    endtask
    // a press is one high cycle of the button; a bare tap queues nothing
    task automatic tap;
        button = 1'b1;
        @(negedge clk);
        button = 1'b0;
        @(negedge clk);
    endtask
    // the resulting state is queued before the press is made
    task automatic press(input logic [1:0] s);
        exp_q.push_back(s);
        tap();
    endtask
    // each state change takes the oldest queued expectation
    always @(negedge clk) begin
        if (!reset && op_state !== last_state)
            check("op_state", op_state, exp_q.size() ? exp_q.pop_front() : 2'bxx);
        last_state <= op_state;
    end
    initial begin
        void'($urandom(54));
        {reset, button, odd_level, last_state} = {1'b1, 1'b0, 16'h0a00, 2'h0};
        {gi, nmask, imask, trim} = {$urandom, $urandom, $urandom, 22'($urandom)};
        repeat (8) @(negedge clk);
        reset = 1'b0;
        check("config address", cfg_a, 32'h0003f000);
        check("program address", prg_a, 32'h00000000);
        check("state after reset", op_state, 2'h0);
        $display("test reset done");
        // channel 5 stuck in the first under-voltage band forces a restart
        press(2'h1);
        wait_for(1'b1, 32'h0, 1'b1);
        check("first enable", regulator_enable, 32'h1);
        wait_for(1'b1, 32'h003fffff, 1'b0);
        wait_for(1'b1, 32'h0, 1'b0);
        check("restart state", op_state, 2'h1);
        odd_level = 16'h1000;
        tap();
        check("ignored start press", op_state, 2'h1);
        exp_q.push_back(2'h2);
        wait_for(1'b0, 2'h2, 1'b0);
        repeat (4) @(negedge clk);
        check("enables on", regulator_enable, 32'h003fffff);
        check("inputs", input_status, gi);
        check("flags", output_flags, (nmask & 32'h003fffff) | (imask & gi));
        $display("test power on done");
        // walk channel 5 through every band while the others stay nominal
        for (k = 0; k < 6; k++) begin
            odd_level = lv[k];
            repeat (4) @(negedge clk);
            check("band", channel_state[17:15], k);
        end
        $display("test bands done");
        press(2'h3);
        exp_q.push_back(2'h0);
        wait_for(1'b1, 32'h003fffff, 1'b1);
        check("first disable", regulator_enable, 32'h001fffff);
        tap();
        check("ignored stop press", op_state, 2'h3);
        wait_for(1'b0, 2'h0, 1'b0);
        repeat (4) @(negedge clk);
        check("enables off", regulator_enable, 32'h0);
        check("flags idle", output_flags, 32'h0);
        check("queue left", exp_q.size(), 32'h0);
        $display("test power off done");
        finish_test();
    end
endmodule // power_supply_sequencer_monitor_tb
bind power_supply_sequencer_monitor seq_chk #(.CHANNELS(CHANNELS), .VW(VW)) i_chk (
    .clk(clk), .reset(reset), .sequence_toggle_button(sequence_toggle_button),
    .channel_voltage(channel_voltage), .trim_allowed(trim_allowed),
    .general_inputs(general_inputs), .regulator_enable(regulator_enable),
    .output_flags(output_flags), .input_status(input_status),
    .voltage_readback(voltage_readback), .channel_state(channel_state), .op_state(op_state),
    .open_trim_enable(open_trim_enable), .closed_trim_enable(closed_trim_enable));

// ===== testbench/regulator_bank.sv
// Purpose: behavioural bank of regulators answering the enables
// Assumes: a rail settles one cycle after its enable changes
// Notes:   channel 5 follows odd_level so that a test can force fault bands
`timescale 1ns/1ps
module regulator_bank (
    input  wire         clk,
    input  wire [31:0]  enable,
    input  wire [15:0]  odd_level,
    output reg  [351:0] volts
);
    integer i;
    // a disabled rail discharges to zero instead of holding its last level
    always @(posedge clk) begin
        for (i = 0; i < 22; i = i + 1)
            volts[i*16+:16] <= !enable[i] ? 16'h0000 : (i == 5 ? odd_level : 16'h1000);
    end
endmodule // regulator_bank

// ===== testbench/seq_chk.sv
// Purpose: port assertions for the power supply sequencer
// Assumes: one clock, synchronous active-high reset
// Notes:   outputs lag state by a cycle, so state is held a few cycles first
`timescale 1ns/1ps
module seq_chk #(parameter CHANNELS = 22, parameter VW = 16) (
    input wire                   clk,
    input wire                   reset,
    input wire                   sequence_toggle_button,
    input wire [CHANNELS*VW-1:0] channel_voltage,
    input wire [CHANNELS-1:0]    trim_allowed,
    input wire [31:0]            general_inputs,
    input wire [31:0]            regulator_enable,
    input wire [31:0]            output_flags,
    input wire [31:0]            input_status,
    input wire [CHANNELS*VW-1:0] voltage_readback,
    input wire [CHANNELS*3-1:0]  channel_state,
    input wire [1:0]             op_state,
    input wire [CHANNELS-1:0]    open_trim_enable,
    input wire [CHANNELS-1:0]    closed_trim_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // leaving stopped, reaching started and leaving started are two-step state moves
    sequence s_leave_stopped;
        op_state == 2'h0 ##1 op_state == 2'h1;
    endsequence
    sequence s_reach_started;
        op_state == 2'h1 ##1 op_state == 2'h2;
    endsequence
    sequence s_leave_started;
        op_state == 2'h2 ##1 op_state == 2'h3;
    endsequence
    AST_START_ON_PRESS: assert property (
        s_leave_stopped |-> $past(sequence_toggle_button) && !$past(sequence_toggle_button, 2))
        else $error("left stopped without a press");
    AST_FULL_ON: assert property (s_reach_started |-> &regulator_enable[CHANNELS-1:0])
        else $error("started before every regulator was on");
    AST_HIGH_ZERO: assert property (regulator_enable[31:CHANNELS] == '0)
        else $error("enable set above the channel count");
    AST_ORDER: assert property (
        op_state != $past(op_state) |-> op_state == $past(op_state) + 2'h1)
        else $error("state moved out of order");
    AST_IDLE: assert property (op_state == 2'h0 [*3] |->
        output_flags == '0 && channel_state == '0 && open_trim_enable == '0)
        else $error("activity while stopped");
    AST_OPEN_TRIM: assert property (op_state == 2'h1 [*3] |->
        open_trim_enable == $past(trim_allowed) && closed_trim_enable == '0)
        else $error("wrong trims while starting");
    AST_CLOSED_TRIM: assert property (op_state == 2'h2 [*3] |->
        closed_trim_enable == $past(trim_allowed) && open_trim_enable == '0)
        else $error("wrong trims while started");
    AST_CLOSED_OFF: assert property (op_state != 2'h2 [*2] |-> closed_trim_enable == '0)
        else $error("closed trim outside started");
    AST_READBACK: assert property (
        !$past(reset) |-> voltage_readback == $past(channel_voltage))
        else $error("voltage readback stale");
    AST_STOP_ON_PRESS: assert property (
        s_leave_started |-> $past(sequence_toggle_button) && !$past(sequence_toggle_button, 2))
        else $error("left started without a press");
    AST_NOMINAL_AT_START: assert property (
        s_reach_started |-> channel_state == {CHANNELS{3'h3}})
        else $error("started with a channel off nominal");
    AST_INPUT_STATUS: assert property (
        !$past(reset) |-> input_status == $past(general_inputs))
        else $error("input status stale");
endmodule // seq_chk
